// File: hdl/iicje_pkg.sv
package iicje_pkg;

  // Operation codes presented with each executed instruction
  typedef enum logic [3:0] {
    IICJE_OP_NOP     = 4'b0000,
    IICJE_OP_INC     = 4'b0001,
    IICJE_OP_DOUBLE_INCREMENT_OP    = 4'b0010,
    IICJE_OP_INV     = 4'b0011,
    IICJE_OP_JC      = 4'b0100,
    IICJE_OP_JZ      = 4'b0101,
    IICJE_OP_JGE     = 4'b0110,
    IICJE_OP_JL      = 4'b0111,
    IICJE_OP_INTERRUPT_ENABLE_OP    = 4'b1000,
    IICJE_OP_DINT    = 4'b1001,
    IICJE_OP_CLRV    = 4'b1010,
    IICJE_OP_LOAD_SR = 4'b1011
  } iicje_op_type;

  localparam int unsigned IICJE_DATA_W = 16;
  localparam int unsigned IICJE_PC_W   = 20;
  localparam int unsigned IICJE_OFFS_W = 10;

  // Status register bit positions used by the load operation
  localparam int unsigned IICJE_SR_C      = 0;
  localparam int unsigned IICJE_SR_Z      = 1;
  localparam int unsigned IICJE_SR_N      = 2;
  localparam int unsigned IICJE_SR_GIE    = 3;
  localparam int unsigned IICJE_SR_CORE_HALT_BIT = 4;
  localparam int unsigned IICJE_SR_OSCILLATOR_OFF_BIT = 5;
  localparam int unsigned IICJE_SR_V      = 8;

  // Operand values that decide the flags
  localparam logic [15:0] IICJE_WORD_ONES   = 16'hFFFF;
  localparam logic [15:0] IICJE_WORD_ONES_1 = 16'hFFFE;
  localparam logic [15:0] IICJE_WORD_SMAX   = 16'h7FFF;
  localparam logic [15:0] IICJE_WORD_SMAX_1 = 16'h7FFE;
  localparam logic [7:0]  IICJE_BYTE_ONES   = 8'hFF;
  localparam logic [7:0]  IICJE_BYTE_ONES_1 = 8'hFE;
  localparam logic [7:0]  IICJE_BYTE_SMAX   = 8'h7F;
  localparam logic [7:0]  IICJE_BYTE_SMAX_1 = 8'h7E;
  localparam logic [15:0] IICJE_STEP_ONE    = 16'h0001;
  localparam logic [15:0] IICJE_STEP_TWO    = 16'h0002;

  // Values after reset
  localparam logic [15:0] IICJE_RESULT_RST  = 16'h0000;
  localparam logic [19:0] IICJE_PC_RST      = 20'h0_0000;

endpackage

// File: hdl/iicje_flag_unit.sv
`timescale 1ns/10ps
module iicje_flag_unit
  import iicje_pkg::*;
(
  input  wire logic        op_inc_i,
  input  wire logic        op_double_increment_op_i,
  input  wire logic        byte_mode_i,
  input  wire logic [15:0] dst_i,
  output logic      [15:0] result_o,
  output logic             flag_n_o,
  output logic             flag_z_o,
  output logic             flag_c_o,
  output logic             flag_v_o
);

  wire logic [15:0] sum_one;
  wire logic [15:0] sum_two;
  wire logic [15:0] raw_res;
  wire logic        is_ones;
  wire logic        is_ones_1;
  wire logic        is_smax;
  wire logic        is_smax_1;
  wire logic        old_msb;
  wire logic        res_zero;

  assign sum_one = dst_i + IICJE_STEP_ONE;
  assign sum_two = dst_i + IICJE_STEP_TWO;
  assign raw_res = op_inc_i ? sum_one : (op_double_increment_op_i ? sum_two : ~dst_i);

  // Byte forms write a zero upper byte, as a register destination would hold
  assign result_o = byte_mode_i ? {8'h00, raw_res[7:0]} : raw_res;

  assign is_ones   = byte_mode_i ? (dst_i[7:0] == IICJE_BYTE_ONES)   : (dst_i == IICJE_WORD_ONES);
  assign is_ones_1 = byte_mode_i ? (dst_i[7:0] == IICJE_BYTE_ONES_1) : (dst_i == IICJE_WORD_ONES_1);
  assign is_smax   = byte_mode_i ? (dst_i[7:0] == IICJE_BYTE_SMAX)   : (dst_i == IICJE_WORD_SMAX);
  assign is_smax_1 = byte_mode_i ? (dst_i[7:0] == IICJE_BYTE_SMAX_1) : (dst_i == IICJE_WORD_SMAX_1);
  assign old_msb   = byte_mode_i ? dst_i[7] : dst_i[15];
  assign res_zero  = (result_o == IICJE_RESULT_RST);

  assign flag_n_o = byte_mode_i ? result_o[7] : result_o[15];

  // Increment Z, C and V are taken from the old value, not from the wrapped sum; invert Z and C come from the result
  assign flag_z_o = op_inc_i  ? is_ones :
                    op_double_increment_op_i ? is_ones_1 :
                                res_zero;
  assign flag_c_o = op_inc_i  ? is_ones :
                    op_double_increment_op_i ? (is_ones | is_ones_1) :
                                ~res_zero;
  assign flag_v_o = op_inc_i  ? is_smax :
                    op_double_increment_op_i ? (is_smax | is_smax_1) :
                                old_msb;

endmodule

// File: hdl/iicje_exec.sv
`timescale 1ns/10ps
// Summary of operation
// - After interrupt enable, the next instruction runs before any interrupt is serviced.
// - Increment adds one to the operand in word or byte width, writes back.
// - Increment sets Z and C only when old operand was all ones.
// - Word increment sets V only when old operand was 7FFFh.
// - Increment, double increment and invert copy result top bit into N.
// - Invert complements every bit of the operand at its width.
// - Invert sets C exactly when the result is nonzero.
// - Invert sets V when the old operand was negative.
// - These operations leave oscillator off, core halt and interrupt enable alone.
// - Conditional jumps never change N, Z, C or V.
// - Taken jump adds twice the sign extended 10-bit offset to PC.
// - Jump if carry branches when C is one, otherwise falls through.
// - Jump if zero branches when Z is one, otherwise falls through.
// - Signed greater or equal jump branches when N equals V.
// - Logic, bit test, shift, sign extend and test operations clear V.
module iicje_exec
  import iicje_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         exec_valid_i,
  input  wire iicje_op_type op_i,
  input  wire logic         byte_mode_i,
  input  wire logic [15:0]  dst_data_i,
  input  wire logic [9:0]   jump_offset_i,
  input  wire logic [19:0]  next_pc_i,
  input  wire logic         ext_n_i,
  input  wire logic         ext_z_i,
  input  wire logic         ext_c_i,
  input  wire logic         irq_pending_i,
  output logic      [15:0]  result_o,
  output logic              result_we_o,
  output logic      [19:0]  pc_o,
  output logic              pc_load_o,
  output logic              flag_n_o,
  output logic              flag_z_o,
  output logic              flag_c_o,
  output logic              flag_v_o,
  output logic              global_irq_enable_bit_o,
  output logic              oscillator_off_bit_o,
  output logic              core_halt_bit_o,
  output logic              irq_accept_o
);

  logic [15:0] result_ff;
  logic        result_we_ff;
  logic [19:0] pc_ff;
  logic        pc_load_ff;
  logic        n_ff;
  logic        z_ff;
  logic        c_ff;
  logic        v_ff;
  logic        gie_ff;
  logic        oscillator_off_bit_ff;
  logic        core_halt_bit_ff;
  logic        irq_hold_ff;

  wire logic        is_inc;
  wire logic        is_double_increment_op;
  wire logic        is_inv;
  wire logic        is_arith;
  wire logic        is_jump;
  wire logic        is_interrupt_enable_op;
  wire logic        is_dint;
  wire logic        is_clrv;
  wire logic        is_load;
  wire logic        jump_cond;
  wire logic        jump_taken;
  wire logic [19:0] jump_disp;
  wire logic [19:0] jump_target;
  wire logic [15:0] alu_res;
  wire logic        alu_n;
  wire logic        alu_z;
  wire logic        alu_c;
  wire logic        alu_v;

  logic [15:0] nxt_result;
  logic        nxt_result_we;
  logic [19:0] nxt_pc;
  logic        nxt_pc_load;
  logic        nxt_n;
  logic        nxt_z;
  logic        nxt_c;
  logic        nxt_v;
  logic        nxt_gie;
  logic        nxt_oscillator_off_bit;
  logic        nxt_core_halt_bit;
  logic        nxt_irq_hold;

  assign is_inc   = exec_valid_i && (op_i == IICJE_OP_INC);
  assign is_double_increment_op  = exec_valid_i && (op_i == IICJE_OP_DOUBLE_INCREMENT_OP);
  assign is_inv   = exec_valid_i && (op_i == IICJE_OP_INV);
  assign is_arith = is_inc || is_double_increment_op || is_inv;
  assign is_jump  = exec_valid_i && ((op_i == IICJE_OP_JC) || (op_i == IICJE_OP_JZ) ||
                                     (op_i == IICJE_OP_JGE) || (op_i == IICJE_OP_JL));
  assign is_interrupt_enable_op  = exec_valid_i && (op_i == IICJE_OP_INTERRUPT_ENABLE_OP);
  assign is_dint  = exec_valid_i && (op_i == IICJE_OP_DINT);
  assign is_clrv  = exec_valid_i && (op_i == IICJE_OP_CLRV);
  assign is_load  = exec_valid_i && (op_i == IICJE_OP_LOAD_SR);

  // Conditions look at the flags held now, so a jump sees the previous instruction's result
  assign jump_cond = (op_i == IICJE_OP_JC)  ? c_ff :
                     (op_i == IICJE_OP_JZ)  ? z_ff :
                     (op_i == IICJE_OP_JGE) ? ~(n_ff ^ v_ff) :
                                              (n_ff ^ v_ff);
  assign jump_taken = is_jump && jump_cond;

  // Offset counts words; the low address bit is always zero
  assign jump_disp   = {{9{jump_offset_i[9]}}, jump_offset_i, 1'b0};
  assign jump_target = next_pc_i + jump_disp;

  // An interrupt is only taken between instructions, never in an execute cycle
  assign irq_accept_o = gie_ff && irq_pending_i && !irq_hold_ff && !exec_valid_i;

  iicje_flag_unit u_flag_unit (
    .op_inc_i    (is_inc),
    .op_double_increment_op_i   (is_double_increment_op),
    .byte_mode_i (byte_mode_i),
    .dst_i       (dst_data_i),
    .result_o    (alu_res),
    .flag_n_o    (alu_n),
    .flag_z_o    (alu_z),
    .flag_c_o    (alu_c),
    .flag_v_o    (alu_v)
  );

  always_comb
  begin
    nxt_result    = result_ff;
    nxt_result_we = 1'b0;
    nxt_pc        = pc_ff;
    nxt_pc_load   = 1'b0;
    nxt_n         = n_ff;
    nxt_z         = z_ff;
    nxt_c         = c_ff;
    nxt_v         = v_ff;
    nxt_gie       = gie_ff;
    nxt_oscillator_off_bit    = oscillator_off_bit_ff;
    nxt_core_halt_bit    = core_halt_bit_ff;
    nxt_irq_hold  = irq_hold_ff;
    if (exec_valid_i)
    begin
      // Any executed instruction ends the shadow; enabling again reopens it
      nxt_irq_hold = is_interrupt_enable_op;
      nxt_pc       = next_pc_i;
      case (op_i)
        IICJE_OP_INC, IICJE_OP_DOUBLE_INCREMENT_OP, IICJE_OP_INV:
        begin
          // Mode bits are deliberately not touched here
          nxt_result    = alu_res;
          nxt_result_we = 1'b1;
          nxt_n         = alu_n;
          nxt_z         = alu_z;
          nxt_c         = alu_c;
          nxt_v         = alu_v;
        end
        IICJE_OP_JC, IICJE_OP_JZ, IICJE_OP_JGE, IICJE_OP_JL:
        begin
          // Flags and mode bits hold whether or not the branch is taken
          nxt_pc      = jump_taken ? jump_target : next_pc_i;
          nxt_pc_load = jump_taken;
        end
        IICJE_OP_INTERRUPT_ENABLE_OP:
          nxt_gie = 1'b1;
        IICJE_OP_DINT:
          nxt_gie = 1'b0;
        IICJE_OP_CLRV:
        begin
          nxt_n = ext_n_i;
          nxt_z = ext_z_i;
          nxt_c = ext_c_i;
          nxt_v = 1'b0;
        end
        IICJE_OP_LOAD_SR:
        begin
          nxt_c      = dst_data_i[IICJE_SR_C];
          nxt_z      = dst_data_i[IICJE_SR_Z];
          nxt_n      = dst_data_i[IICJE_SR_N];
          nxt_gie    = dst_data_i[IICJE_SR_GIE];
          nxt_core_halt_bit = dst_data_i[IICJE_SR_CORE_HALT_BIT];
          nxt_oscillator_off_bit = dst_data_i[IICJE_SR_OSCILLATOR_OFF_BIT];
          nxt_v      = dst_data_i[IICJE_SR_V];
        end
        default:
          nxt_pc = next_pc_i;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      result_ff    <= IICJE_RESULT_RST;
      result_we_ff <= 1'b0;
      pc_ff        <= IICJE_PC_RST;
      pc_load_ff   <= 1'b0;
      n_ff         <= 1'b0;
      z_ff         <= 1'b0;
      c_ff         <= 1'b0;
      v_ff         <= 1'b0;
      gie_ff       <= 1'b0;
      oscillator_off_bit_ff    <= 1'b0;
      core_halt_bit_ff    <= 1'b0;
      irq_hold_ff  <= 1'b0;
    end
    else
    begin
      result_ff    <= nxt_result;
      result_we_ff <= nxt_result_we;
      pc_ff        <= nxt_pc;
      pc_load_ff   <= nxt_pc_load;
      n_ff         <= nxt_n;
      z_ff         <= nxt_z;
      c_ff         <= nxt_c;
      v_ff         <= nxt_v;
      gie_ff       <= nxt_gie;
      oscillator_off_bit_ff    <= nxt_oscillator_off_bit;
      core_halt_bit_ff    <= nxt_core_halt_bit;
      irq_hold_ff  <= nxt_irq_hold;
    end
  end

  assign result_o                = result_ff;
  assign result_we_o             = result_we_ff;
  assign pc_o                    = pc_ff;
  assign pc_load_o               = pc_load_ff;
  assign flag_n_o                = n_ff;
  assign flag_z_o                = z_ff;
  assign flag_c_o                = c_ff;
  assign flag_v_o                = v_ff;
  assign global_irq_enable_bit_o = gie_ff;
  assign oscillator_off_bit_o    = oscillator_off_bit_ff;
  assign core_halt_bit_o         = core_halt_bit_ff;

  default clocking ast_clk @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_enable_then_idle;
    is_interrupt_enable_op ##1 !exec_valid_i;
  endsequence

  sequence s_enable_then_next;
    is_interrupt_enable_op ##1 (exec_valid_i && (op_i != IICJE_OP_INTERRUPT_ENABLE_OP));
  endsequence

  AST_INTERRUPT_ENABLE_OP_SHADOW:
    assert property (s_enable_then_idle |-> !irq_accept_o)
    else $error("Interrupt accepted before the instruction after enable");

  AST_INTERRUPT_ENABLE_OP_SHADOW_END:
    assert property (s_enable_then_next ##1 !exec_valid_i |->
                     (irq_accept_o == (irq_pending_i && global_irq_enable_bit_o)))
    else $error("Interrupt still held after the following instruction");

  AST_INC_WORD:
    assert property (is_inc && !byte_mode_i |=>
                     result_we_o && (result_o == 16'($past(dst_data_i) + IICJE_STEP_ONE)))
    else $error("Word increment result wrong");

  AST_INC_ZC:
    assert property (is_inc |=> (flag_z_o == flag_c_o) &&
                     (flag_z_o == ($past(byte_mode_i) ? ($past(dst_data_i[7:0]) == IICJE_BYTE_ONES)
                                                      : ($past(dst_data_i) == IICJE_WORD_ONES))))
    else $error("Increment Z or C wrong");

  AST_INC_V:
    assert property (is_inc && !byte_mode_i |=> flag_v_o == ($past(dst_data_i) == IICJE_WORD_SMAX))
    else $error("Word increment V wrong");

  AST_N_MSB:
    assert property (result_we_o |-> flag_n_o == ($past(byte_mode_i) ? result_o[7] : result_o[15]))
    else $error("N does not follow result top bit");

  AST_DOUBLE_INCREMENT_OP_BYTE:
    assert property (is_double_increment_op && byte_mode_i |=> result_o == {8'h00, 8'($past(dst_data_i[7:0]) + 8'h02)})
    else $error("Byte double increment result wrong");

  AST_DOUBLE_INCREMENT_OP_FLAGS:
    assert property (is_double_increment_op && !byte_mode_i |=>
                     (flag_c_o == ($past(dst_data_i) >= IICJE_WORD_ONES_1)) &&
                     (flag_z_o == ($past(dst_data_i) == IICJE_WORD_ONES_1)) &&
                     (flag_v_o == ($past(dst_data_i[15:1]) == IICJE_WORD_SMAX_1[15:1])))
    else $error("Word double increment flags wrong");

  AST_INV_ALL:
    assert property (is_inv && !byte_mode_i |=>
                     (result_o == ~$past(dst_data_i)) && (flag_c_o == !flag_z_o) &&
                     (flag_z_o == (result_o == IICJE_RESULT_RST)) && (flag_v_o == $past(dst_data_i[15])))
    else $error("Invert result or flags wrong");

  AST_INV_C:
    assert property (is_inv |=> flag_c_o != flag_z_o)
    else $error("Invert C not complement of Z");

  AST_MODE_KEEP:
    assert property (is_arith || is_jump |=>
                     $stable(global_irq_enable_bit_o) && $stable(oscillator_off_bit_o) && $stable(core_halt_bit_o))
    else $error("Mode bit changed by increment, invert or jump");

  AST_JUMP_FLAGS:
    assert property (is_jump |=> $stable(flag_n_o) && $stable(flag_z_o) && $stable(flag_c_o) && $stable(flag_v_o))
    else $error("Jump changed a status flag");

  AST_JC_TARGET:
    assert property (exec_valid_i && (op_i == IICJE_OP_JC) && flag_c_o |=>
                     pc_load_o && (pc_o == 20'($past(next_pc_i) + {{9{$past(jump_offset_i[9])}},
                                                                   $past(jump_offset_i), 1'b0})))
    else $error("Carry jump target wrong");

  AST_JZ_FALL:
    assert property (exec_valid_i && (op_i == IICJE_OP_JZ) && !flag_z_o |=>
                     !pc_load_o && (pc_o == $past(next_pc_i)))
    else $error("Zero jump taken with Z clear");

  AST_SIGNED_JUMP:
    assert property (exec_valid_i && (op_i == IICJE_OP_JL) |=> pc_load_o == $past(flag_n_o ^ flag_v_o))
    else $error("Signed less jump decision wrong");

  AST_CLEAR_V:
    assert property (is_clrv |=> !flag_v_o ##1 ((flag_v_o == $past(flag_v_o)) || $past(is_arith || is_load)))
    else $error("V not cleared by logic or test operation");

endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import iicje_pkg::*;
  logic         clk_sys_i;
  logic         rst_i;
  logic         exec_valid_i;
  iicje_op_type op_i;
  logic         byte_mode_i;
  logic [15:0]  dst_data_i;
  logic [9:0]   jump_offset_i;
  logic [19:0]  next_pc_i;
  logic         ext_n_i;
  logic         ext_z_i;
  logic         ext_c_i;
  logic         irq_pending_i;
  logic [15:0]  result_o;
  logic         result_we_o;
  logic [19:0]  pc_o;
  logic         pc_load_o;
  logic         flag_n_o;
  logic         flag_z_o;
  logic         flag_c_o;
  logic         flag_v_o;
  logic         global_irq_enable_bit_o;
  logic         oscillator_off_bit_o;
  logic         core_halt_bit_o;
  logic         irq_accept_o;
  int           n_mismatch;
  int           total_checks;
  int           seed;
  logic [15:0]  m_res;
  logic [19:0]  m_pc;
  logic         m_we, m_ld, m_n, m_z, m_c, m_v, m_gie, m_osc, m_cpu, m_sh;
  logic [15:0]  vals [10] = '{16'hFFFF, 16'hFFFE, 16'h7FFF, 16'h7FFE, 16'h80FF,
                              16'h00FE, 16'h007F, 16'h007E, 16'h0000, 16'h0080};
  logic [9:0]   offs [4] = '{10'h1FF, 10'h200, 10'h3FF, 10'h000};

  iicje_exec dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .exec_valid_i(exec_valid_i), .op_i(op_i),
    .byte_mode_i(byte_mode_i), .dst_data_i(dst_data_i), .jump_offset_i(jump_offset_i),
    .next_pc_i(next_pc_i), .ext_n_i(ext_n_i), .ext_z_i(ext_z_i), .ext_c_i(ext_c_i),
    .irq_pending_i(irq_pending_i), .result_o(result_o), .result_we_o(result_we_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .flag_c_o(flag_c_o),
    .flag_v_o(flag_v_o), .global_irq_enable_bit_o(global_irq_enable_bit_o),
    .oscillator_off_bit_o(oscillator_off_bit_o), .core_halt_bit_o(core_halt_bit_o),
    .irq_accept_o(irq_accept_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic model_reset();
    {m_res, m_pc} = '0;
    {m_we, m_ld, m_n, m_z, m_c, m_v, m_gie, m_osc, m_cpu, m_sh} = '0;
  endtask

  // Reference step, evaluated with the inputs seen at the sampling edge
  task automatic model();
    int ones, smax, old, res;
    logic t;
    m_we = 1'b0;
    m_ld = 1'b0;
    if (exec_valid_i)
    begin
      m_sh = (op_i == IICJE_OP_INTERRUPT_ENABLE_OP);
      m_pc = next_pc_i;
      ones = byte_mode_i ? 'hFF : 'hFFFF;
      smax = byte_mode_i ? 'h7F : 'h7FFF;
      old  = byte_mode_i ? int'(dst_data_i[7:0]) : int'(dst_data_i);
      t    = 1'b0;
      case (op_i)
        IICJE_OP_INC, IICJE_OP_DOUBLE_INCREMENT_OP, IICJE_OP_INV:
        begin
          res = (op_i == IICJE_OP_INV) ? (~old & ones) : ((old + ((op_i == IICJE_OP_INC) ? 1 : 2)) & ones);
          m_res = res[15:0];
          m_we = 1'b1;
          m_n = (res > smax);
          if (op_i == IICJE_OP_INC)
          begin
            m_z = (old == ones);
            m_c = (old == ones);
            m_v = (old == smax);
          end
          else if (op_i == IICJE_OP_DOUBLE_INCREMENT_OP)
          begin
            m_z = (old == ones - 1);
            m_c = (old >= ones - 1);
            m_v = (old == smax) || (old == smax - 1);
          end
          else
          begin
            m_z = (res == 0);
            m_c = (res != 0);
            m_v = (old > smax);
          end
        end
        IICJE_OP_JC:      t = m_c;
        IICJE_OP_JZ:      t = m_z;
        IICJE_OP_JGE:     t = ~(m_n ^ m_v);
        IICJE_OP_JL:      t = m_n ^ m_v;
        IICJE_OP_INTERRUPT_ENABLE_OP:    m_gie = 1'b1;
        IICJE_OP_DINT:    m_gie = 1'b0;
        IICJE_OP_CLRV:    {m_n, m_z, m_c, m_v} = {ext_n_i, ext_z_i, ext_c_i, 1'b0};
        IICJE_OP_LOAD_SR:
        begin
          {m_n, m_z, m_c, m_v} = {dst_data_i[2], dst_data_i[1], dst_data_i[0], dst_data_i[8]};
          {m_gie, m_cpu, m_osc} = {dst_data_i[3], dst_data_i[4], dst_data_i[5]};
        end
        default: ;
      endcase
      if (t)
      begin
        m_pc = next_pc_i + {{9{jump_offset_i[9]}}, jump_offset_i, 1'b0};
        m_ld = 1'b1;
      end
    end
  endtask

  task automatic chk_all();
    chk("result", 20'(result_o), 20'(m_res));
    chk("result_we", 20'(result_we_o), 20'(m_we));
    chk("pc", pc_o, m_pc);
    chk("pc_load", 20'(pc_load_o), 20'(m_ld));
    chk("flag_n", 20'(flag_n_o), 20'(m_n));
    chk("flag_z", 20'(flag_z_o), 20'(m_z));
    chk("flag_c", 20'(flag_c_o), 20'(m_c));
    chk("flag_v", 20'(flag_v_o), 20'(m_v));
    chk("mode", 20'({global_irq_enable_bit_o, core_halt_bit_o, oscillator_off_bit_o}),
        20'({m_gie, m_cpu, m_osc}));
  endtask

  // One clock of stimulus, launched just after the rising edge
  task automatic cyc(input logic v, input iicje_op_type op, input logic b, input logic [15:0] d,
                     input logic [9:0] off, input logic p);
    exec_valid_i = v;
    op_i = op;
    byte_mode_i = b;
    dst_data_i = d;
    jump_offset_i = off;
    next_pc_i = 20'($random(seed)) & 20'hF_FFFE;
    {ext_n_i, ext_z_i, ext_c_i} = 3'($random(seed));
    irq_pending_i = p;
    @(negedge clk_sys_i);
    chk("irq_accept", 20'(irq_accept_o), 20'(m_gie & p & ~m_sh & ~v));
    @(posedge clk_sys_i);
    model();
    #1;
    chk_all();
  endtask

  task automatic do_reset(input int n);
    rst_i = 1'b1;
    repeat (n) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    model_reset();
    chk_all();
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    $display("[FAIL] watchdog expected end seen hang");
    close_out();
  end

  initial
  begin
    seed = 32'hbf2e_0b3c;
    n_mismatch = 0;
    total_checks = 0;
    {exec_valid_i, byte_mode_i, ext_n_i, ext_z_i, ext_c_i, irq_pending_i} = '0;
    op_i = IICJE_OP_NOP;
    dst_data_i = 16'h0000;
    jump_offset_i = 10'h000;
    next_pc_i = 20'h0_0000;
    model_reset();
    do_reset(20);
    // Oscillator off and core halt bits set first so that any disturbance of them shows
    cyc(1, IICJE_OP_LOAD_SR, 0, 16'h0030, 10'h000, 0);
    foreach (vals[i])
      for (int k = 1; k <= 3; k++)
        for (int b = 0; b < 2; b++)
          cyc(1, iicje_op_type'(k), b[0], vals[i], 10'($random(seed)), 0);
    for (int f = 0; f < 16; f++)
      for (int j = 0; j < 4; j++)
      begin
        cyc(1, IICJE_OP_LOAD_SR, 0, {7'h00, f[3], 2'b00, 3'b011, f[2:0]}, 10'h000, 0);
        cyc(1, iicje_op_type'(4 + j), 0, 16'($random(seed)), offs[(f + j) % 4], 0);
        cyc(1, iicje_op_type'(4 + j), 0, 16'h0000, offs[j], 0);
      end
    repeat (8)
    begin
      cyc(1, IICJE_OP_CLRV, 0, 16'h0000, 10'h000, 0);
      cyc(1, IICJE_OP_JGE, 0, 16'h0000, 10'h155, 0);
    end
    // Request already pending when interrupts are enabled
    cyc(1, IICJE_OP_LOAD_SR, 0, 16'h0000, 10'h000, 1);
    cyc(0, IICJE_OP_NOP, 0, 16'h0000, 10'h000, 1);
    cyc(1, IICJE_OP_INTERRUPT_ENABLE_OP, 0, 16'h0000, 10'h000, 1);
    cyc(0, IICJE_OP_NOP, 0, 16'h0000, 10'h000, 1);
    cyc(1, IICJE_OP_INTERRUPT_ENABLE_OP, 0, 16'h0000, 10'h000, 1);
    cyc(0, IICJE_OP_NOP, 0, 16'h0000, 10'h000, 1);
    cyc(1, IICJE_OP_INC, 0, 16'h1234, 10'h000, 1);
    cyc(0, IICJE_OP_NOP, 0, 16'h0000, 10'h000, 1);
    cyc(1, IICJE_OP_DINT, 0, 16'h0000, 10'h000, 1);
    cyc(0, IICJE_OP_NOP, 0, 16'h0000, 10'h000, 1);
    for (int r = 0; r < 2; r++)
    begin
      repeat (400)
        cyc(($random(seed) % 5) != 0, iicje_op_type'($unsigned($random(seed)) % 12), 1'($random(seed)),
            ($random(seed) & 1) ? 16'($random(seed)) : vals[$unsigned($random(seed)) % 10],
            10'($random(seed)), 1'($random(seed)));
      do_reset(2);
    end
    close_out();
  end
endmodule
